//--- mpp_defines.svh
// Command codes, status layout and timing counts of the page program link.
`ifndef MPP_DEFINES_SVH
`define MPP_DEFINES_SVH
`define MPP_CMD_WREN 8'h06
`define MPP_CMD_RDSR 8'h05
`define MPP_CMD_ASI 8'h25
`define MPP_CMD_DUAL 8'ha2
`define MPP_CMD_QUAD 8'h32
`define MPP_HDR_LAST 5'h1f
`define MPP_CMD_LAST 5'h07
`define MPP_HDR_BITS 13'h0020
`define MPP_RDSR_CLKS 13'h0010
`define MPP_WREN_CLKS 13'h0008
`define MPP_ASI_CLKS 13'h1fff
`define MPP_PAGE_BYTES 9'h100
`define MPP_SR_BUSY 0
`define MPP_SR_WEL 1
`define MPP_BYTE_NS 100
`define MPP_CLK_NS 5
`define MPP_BYTE_CYC ((`MPP_BYTE_NS + `MPP_CLK_NS - 1) / `MPP_CLK_NS)
`define MPP_SCLK_HALF 4'h5
`endif

//--- mpp_pkg.sv
// Types of the host end and the flash end of the page program link; each type serves one end.
package mpp_pkg;
    typedef enum logic [2:0] {
        L_CMD = 3'h0, L_ADDR = 3'h1, L_DATA = 3'h2,
        L_STAT = 3'h3, L_ACT = 3'h4, L_SKIP = 3'h5
    } mpp_lst_t;
    typedef enum logic [1:0] {
        S_IDLE = 2'h0, S_PROG = 2'h1, S_WAIT = 2'h2
    } mpp_sst_t;
    typedef enum logic [1:0] {
        H_IDLE = 2'h0, H_RUN = 2'h1, H_END = 2'h2, H_GAP = 2'h3
    } mpp_hst_t;
    typedef enum logic [2:0] {
        OP_WREN = 3'h0, OP_RDSR = 3'h1, OP_ASI = 3'h2,
        OP_DUAL = 3'h3, OP_QUAD = 3'h4
    } mpp_op_t;
endpackage

//--- mpp_link_if.sv
// Serial link between the host end and the flash end.
`timescale 1ns/1ps
interface mpp_link_if;
    logic sclk;
    logic cs_n;
    logic si;
    logic wp;
    logic hold;
    logic so_dev;
    logic so_dev_oe_n;
    logic so_host;
    logic so_host_oe_n;
    logic so;
    // The shared output lane idles high when nobody drives it.
    assign so = !so_dev_oe_n ? so_dev : (!so_host_oe_n ? so_host : 1'b1);
    modport dev(input sclk, cs_n, si, wp, hold, so,
                output so_dev, so_dev_oe_n);
    modport host(output sclk, cs_n, si, wp, hold, so_host, so_host_oe_n,
                 input so);
endinterface

//--- mpp_flash_end.sv
// Flash end: takes dual and quad page program frames and programs a page.
// Function
// - Dual program needs write enable latch set.
// - Command then 24-bit address, MSB first.
// - Output lane becomes input after address.
// - Dual data: high bit output lane, low input.
// - Busy flag readable by status read during programming.
// - Active status drives busy on output each clock.
// - Data past page end wraps to page start.
// - Program buffered bytes at release; keep last 256.
// - Incomplete header, data or byte aborts programming.
// - Protected target: skip, clear write enable latch.
// - Failed byte sets erase and program error.
// - Quad program needs write enable and quad enable.
// - Quad: header on input lane, two clocks per byte.
// - Quad lanes: hold, protect, output, input.
// - Incomplete quad address or byte aborts, clears latch.
`timescale 1ns/1ps
`include "mpp_defines.svh"
module mpp_flash_end
    import mpp_pkg::*;
(
    // System side.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Configuration.
    input wire logic quad_lane_enable_i,
    input wire logic [7:0] protect_i,
    // Array write port.
    input wire logic mem_fail_i,
    output logic mem_we_o,
    output logic [23:0] mem_addr_o,
    output logic [7:0] mem_data_o,
    // Status.
    input wire logic err_clr_i,
    output logic busy_flag_o,
    output logic write_enable_latch_o,
    output logic erase_error_flag_o,
    output logic program_error_flag_o,
    // Link.
    mpp_link_if.dev link
);
    typedef struct packed {
        mpp_lst_t lst;
        logic [4:0] cnt;
        logic [7:0] sh;
        logic prog;
        logic quad;
        logic [23:0] addr;
        logic addr_done;
        logic [1:0] sub;
        logic [7:0] db;
        logic [7:0] ptr;
        logic [8:0] nbytes;
        logic partial;
        logic wren;
        logic frm;
        logic [7:0] stat;
        logic so;
        logic so_oe_n;
        logic busy_s1;
        logic busy_s2;
        logic wel_s1;
        logic wel_s2;
        logic qe_s1;
        logic qe_s2;
    } mpp_lnk_t;

    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic fr1;
        logic fr2;
        logic fseen;
        logic write_enable_latch;
        logic busy;
        logic ee;
        logic pe;
        mpp_sst_t sst;
        logic [8:0] idx;
        logic [8:0] cnt;
        logic [7:0] tmr;
        logic [7:0] start;
        logic [15:0] base;
        logic fchk;
        logic mem_we;
        logic [23:0] mem_addr;
        logic [7:0] mem_data;
    } mpp_sys_t;

    localparam logic [7:0] BYTE_CYC = 8'(`MPP_BYTE_CYC);

    mpp_lnk_t l;
    mpp_lnk_t next_l;
    mpp_sys_t s;
    mpp_sys_t next_s;
    logic live;
    logic bwr;
    logic [7:0] bdat;
    logic [7:0] cmd_w;
    logic [23:0] addr_w;
    logic [7:0] sr1;
    logic last;
    logic [7:0] pbuf [0:255];

    // Marks that the current frame has seen its first clock edge.
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end

    always_comb begin
        next_l = l;
        bwr = 1'b0;
        bdat = l.db;
        cmd_w = {l.sh[6:0], link.si};
        addr_w = {l.addr[22:0], link.si};
        sr1 = 8'h00;
        sr1[`MPP_SR_BUSY] = l.busy_s2;
        sr1[`MPP_SR_WEL] = l.wel_s2;
        last = l.quad ? (l.sub == 2'h1) : (l.sub == 2'h3);
        next_l.busy_s1 = s.busy;
        next_l.busy_s2 = l.busy_s1;
        next_l.wel_s1 = s.write_enable_latch;
        next_l.wel_s2 = l.wel_s1;
        next_l.qe_s1 = quad_lane_enable_i;
        next_l.qe_s2 = l.qe_s1;
        if (!live) begin
            next_l.lst = L_CMD;
            next_l.cnt = 5'h01;
            next_l.sh = {7'h00, link.si};
            next_l.prog = 1'b0;
            next_l.addr_done = 1'b0;
            next_l.nbytes = 9'h000;
            next_l.partial = 1'b0;
            next_l.wren = 1'b0;
            next_l.frm = ~l.frm;
            next_l.so_oe_n = 1'b1;
        end else begin
            case (l.lst)
                L_CMD: begin
                    next_l.sh = cmd_w;
                    next_l.cnt = l.cnt + 5'h01;
                    if (l.cnt == `MPP_CMD_LAST) begin
                        next_l.lst = L_SKIP;
                        case (cmd_w)
                            `MPP_CMD_WREN: begin
                                next_l.wren = 1'b1;
                            end
                            `MPP_CMD_RDSR: begin
                                next_l.lst = L_STAT;
                                next_l.so = sr1[7];
                                next_l.stat = {sr1[6:0], 1'b0};
                                next_l.so_oe_n = 1'b0;
                            end
                            `MPP_CMD_ASI: begin
                                next_l.lst = L_ACT;
                                next_l.so = l.busy_s2;
                                next_l.so_oe_n = 1'b0;
                            end
                            `MPP_CMD_DUAL: begin
                                if (l.wel_s2) begin
                                    next_l.lst = L_ADDR;
                                    next_l.prog = 1'b1;
                                    next_l.quad = 1'b0;
                                end
                            end
                            `MPP_CMD_QUAD: begin
                                if (l.wel_s2 && l.qe_s2) begin
                                    next_l.lst = L_ADDR;
                                    next_l.prog = 1'b1;
                                    next_l.quad = 1'b1;
                                end
                            end
                            default: begin
                                next_l.lst = L_SKIP;
                            end
                        endcase
                    end
                end
                L_ADDR: begin
                    next_l.addr = addr_w;
                    next_l.cnt = l.cnt + 5'h01;
                    if (l.cnt == `MPP_HDR_LAST) begin
                        next_l.addr_done = 1'b1;
                        next_l.ptr = addr_w[7:0];
                        next_l.sub = 2'h0;
                        next_l.lst = L_DATA;
                        next_l.so_oe_n = 1'b1;
                    end
                end
                L_DATA: begin
                    if (l.quad) begin
                        next_l.db = {l.db[3:0], link.hold, link.wp,
                                     link.so, link.si};
                    end else begin
                        next_l.db = {l.db[5:0], link.so, link.si};
                    end
                    next_l.sub = last ? 2'h0 : l.sub + 2'h1;
                    next_l.partial = !last;
                    if (last) begin
                        bwr = 1'b1;
                        bdat = next_l.db;
                        next_l.ptr = l.ptr + 8'h01;
                        if (l.nbytes != `MPP_PAGE_BYTES) begin
                            next_l.nbytes = l.nbytes + 9'h001;
                        end
                    end
                end
                L_STAT: begin
                    next_l.so = l.stat[7];
                    next_l.stat = {l.stat[6:0], 1'b0};
                end
                L_ACT: begin
                    next_l.so = l.busy_s2;
                end
                default: begin
                    next_l.lst = L_SKIP;
                end
            endcase
        end
    end

    // The link logic is cleared directly by the system reset because the
    // serial clock stands still outside frames.
    always_ff @(posedge link.sclk or posedge srst_i) begin
        if (srst_i) begin
            l <= '0;
            l.so_oe_n <= 1'b1;
        end else begin
            l <= next_l;
        end
    end

    // Each write lands at its wrapped page slot, so later bytes overwrite.
    always_ff @(posedge link.sclk) begin
        if (bwr) begin
            pbuf[l.ptr] <= bdat;
        end
    end

    // The buffer and frame fields are read only after the release of chip
    // select, while the serial clock is stopped and they stand still.
    always_comb begin
        next_s = s;
        next_s.cs1 = link.cs_n;
        next_s.cs2 = s.cs1;
        next_s.cs3 = s.cs2;
        next_s.fr1 = l.frm;
        next_s.fr2 = s.fr1;
        next_s.mem_we = 1'b0;
        if (err_clr_i) begin
            next_s.ee = 1'b0;
            next_s.pe = 1'b0;
        end
        // A frame that ends while programming still counts as seen.
        if (s.cs2 && !s.cs3) begin
            next_s.fseen = s.fr2;
        end
        case (s.sst)
            S_IDLE: begin
                if (s.cs2 && !s.cs3 && (s.fr2 != s.fseen)) begin
                    if (l.wren) begin
                        next_s.write_enable_latch = 1'b1;
                    end
                    if (l.prog) begin
                        if (!l.addr_done || l.nbytes == 9'h000
                            || l.partial) begin
                            next_s.write_enable_latch = 1'b0;
                        end else if (protect_i[l.addr[18:16]]) begin
                            next_s.write_enable_latch = 1'b0;
                        end else begin
                            next_s.busy = 1'b1;
                            next_s.start = l.addr[7:0];
                            next_s.cnt = l.nbytes;
                            next_s.idx = 9'h000;
                            next_s.base = l.addr[23:8];
                            next_s.sst = S_PROG;
                        end
                    end
                end
            end
            S_PROG: begin
                next_s.mem_we = 1'b1;
                next_s.mem_addr = {s.base, s.start + s.idx[7:0]};
                next_s.mem_data = pbuf[s.start + s.idx[7:0]];
                next_s.idx = s.idx + 9'h001;
                next_s.tmr = BYTE_CYC;
                next_s.fchk = 1'b1;
                next_s.sst = S_WAIT;
            end
            S_WAIT: begin
                next_s.fchk = 1'b0;
                if (s.fchk && mem_fail_i) begin
                    next_s.ee = 1'b1;
                    next_s.pe = 1'b1;
                end
                next_s.tmr = s.tmr - 8'h01;
                if (s.tmr <= 8'h01) begin
                    if (s.idx == s.cnt) begin
                        next_s.busy = 1'b0;
                        next_s.write_enable_latch = 1'b0;
                        next_s.sst = S_IDLE;
                    end else begin
                        next_s.sst = S_PROG;
                    end
                end
            end
            default: begin
                next_s.sst = S_IDLE;
            end
        endcase
        if (!ce_i) begin
            next_s = s;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s <= '0;
            s.cs1 <= 1'b1;
            s.cs2 <= 1'b1;
            s.cs3 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.so_dev = l.so;
    assign link.so_dev_oe_n = l.so_oe_n;
    assign mem_we_o = s.mem_we;
    assign mem_addr_o = s.mem_addr;
    assign mem_data_o = s.mem_data;
    assign busy_flag_o = s.busy;
    assign write_enable_latch_o = s.write_enable_latch;
    assign erase_error_flag_o = s.ee;
    assign program_error_flag_o = s.pe;
endmodule

//--- mpp_host_end.sv
// Host end: builds program, write enable and status frames on the link.
`timescale 1ns/1ps
`include "mpp_defines.svh"
module mpp_host_end
    import mpp_pkg::*;
(
    // System side.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Request.
    input wire logic req_i,
    input wire mpp_op_t op_i,
    input wire logic [23:0] addr_i,
    input wire logic [9:0] len_i,
    input wire logic [2:0] extra_i,
    input wire logic [7:0] byte_i,
    output logic ready_o,
    output logic byte_take_o,
    output logic done_o,
    output logic [7:0] status_o,
    // Link.
    mpp_link_if.host link
);
    typedef struct packed {
        mpp_hst_t hst;
        mpp_op_t op;
        logic [3:0] div;
        logic [12:0] idx;
        logic [12:0] total;
        logic [31:0] hdr;
        logic [7:0] b;
        logic sclk;
        logic cs_n;
        logic [4:0] lanes;
        logic s1;
        logic s2;
        logic [7:0] stat;
        logic done;
        logic take;
    } mpp_hreg_t;

    mpp_hreg_t h;
    mpp_hreg_t next_h;
    logic [12:0] k;
    logic [12:0] dk;
    logic bnd;
    logic [7:0] bsel;
    logic stop;

    // Returns {output enable low, hold, protect, output, input} for clock k.
    function automatic logic [4:0] lane_f(input mpp_op_t op,
                                          input logic [31:0] hdr,
                                          input logic [12:0] kk,
                                          input logic [7:0] b);
        logic [12:0] d;
        logic [7:0] sel;
        d = kk - `MPP_HDR_BITS;
        sel = 8'h00;
        lane_f = {2'h3, 2'h0, hdr[5'h1f - kk[4:0]]};
        if (op == OP_DUAL && kk >= `MPP_HDR_BITS) begin
            sel = b << {d[1:0], 1'b0};
            lane_f = {1'b0, 2'h3, sel[7], sel[6]};
        end else if (op == OP_QUAD && kk >= `MPP_HDR_BITS) begin
            sel = b << {d[0], 2'h0};
            lane_f = {1'b0, sel[7:4]};
        end
    endfunction

    always_comb begin
        next_h = h;
        next_h.s1 = link.so;
        next_h.s2 = h.s1;
        next_h.done = 1'b0;
        next_h.take = 1'b0;
        k = h.idx + 13'h0001;
        dk = k - `MPP_HDR_BITS;
        bnd = (h.op == OP_QUAD) ? !dk[0] : (dk[1:0] == 2'h0);
        bsel = h.b;
        stop = 1'b0;
        case (h.hst)
            H_IDLE: begin
                if (req_i) begin
                    next_h.op = op_i;
                    next_h.idx = 13'h0000;
                    next_h.div = 4'h0;
                    next_h.sclk = 1'b0;
                    next_h.cs_n = 1'b0;
                    next_h.hst = H_RUN;
                    case (op_i)
                        OP_DUAL: begin
                            next_h.hdr = {`MPP_CMD_DUAL, addr_i};
                            next_h.total = `MPP_HDR_BITS
                                + {1'b0, len_i, 2'h0} + 13'(extra_i);
                        end
                        OP_QUAD: begin
                            next_h.hdr = {`MPP_CMD_QUAD, addr_i};
                            next_h.total = `MPP_HDR_BITS
                                + {2'h0, len_i, 1'b0} + 13'(extra_i);
                        end
                        OP_RDSR: begin
                            next_h.hdr = {`MPP_CMD_RDSR, 24'h000000};
                            next_h.total = `MPP_RDSR_CLKS;
                        end
                        OP_ASI: begin
                            next_h.hdr = {`MPP_CMD_ASI, 24'h000000};
                            next_h.total = `MPP_ASI_CLKS;
                        end
                        default: begin
                            next_h.hdr = {`MPP_CMD_WREN, 24'h000000};
                            next_h.total = `MPP_WREN_CLKS;
                        end
                    endcase
                    next_h.lanes = lane_f(op_i, next_h.hdr, 13'h0000,
                                          8'h00);
                end
            end
            H_RUN: begin
                next_h.div = h.div + 4'h1;
                if (h.div == `MPP_SCLK_HALF - 4'h1) begin
                    next_h.div = 4'h0;
                    next_h.sclk = ~h.sclk;
                    if (h.sclk) begin
                        if (h.op == OP_RDSR && h.idx >= 13'h0007
                            && h.idx <= 13'h000e) begin
                            next_h.stat = {h.stat[6:0], h.s2};
                        end
                        if (h.op == OP_ASI && h.idx >= 13'h0007) begin
                            next_h.stat = {7'h00, h.s2};
                            stop = !h.s2;
                        end
                        if (k == h.total || stop) begin
                            next_h.hst = H_END;
                        end else begin
                            next_h.idx = k;
                            if (k >= `MPP_HDR_BITS && bnd) begin
                                bsel = byte_i;
                                next_h.b = byte_i;
                                next_h.take = 1'b1;
                            end
                            next_h.lanes = lane_f(h.op, h.hdr, k, bsel);
                        end
                    end
                end
            end
            H_END: begin
                next_h.div = h.div + 4'h1;
                if (h.div == `MPP_SCLK_HALF - 4'h1) begin
                    next_h.div = 4'h0;
                    next_h.cs_n = 1'b1;
                    next_h.lanes = 5'h1c;
                    next_h.done = 1'b1;
                    next_h.hst = H_GAP;
                end
            end
            default: begin
                next_h.div = h.div + 4'h1;
                if (h.div == `MPP_SCLK_HALF - 4'h1) begin
                    next_h.div = 4'h0;
                    next_h.hst = H_IDLE;
                end
            end
        endcase
        if (!ce_i) begin
            next_h = h;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            h <= '0;
            h.cs_n <= 1'b1;
            h.lanes <= 5'h1c;
            h.s1 <= 1'b1;
            h.s2 <= 1'b1;
        end else begin
            h <= next_h;
        end
    end

    assign link.sclk = h.sclk;
    assign link.cs_n = h.cs_n;
    assign link.so_host_oe_n = h.lanes[4];
    assign link.hold = h.lanes[3];
    assign link.wp = h.lanes[2];
    assign link.so_host = h.lanes[1];
    assign link.si = h.lanes[0];
    assign ready_o = (h.hst == H_IDLE);
    assign byte_take_o = h.take;
    assign done_o = h.done;
    assign status_o = h.stat;
endmodule

//--- mpp_link_sva.sv
// Checker for the wire protocol between the two page program ends.
`timescale 1ns/1ps
`include "mpp_defines.svh"
module mpp_link_sva (
    // System clock.
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Link.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_dev,
    input wire logic so_dev_oe_n,
    input wire logic so_host_oe_n
);
    logic [5:0] cnt;
    logic [7:0] cmd;
    // Counts link clocks in a frame and captures the command byte.
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt <= 6'h00;
            cmd <= 8'h00;
        end else begin
            if (cnt != 6'h3f) begin
                cnt <= cnt + 6'h01;
            end
            if (cnt < 6'h08) begin
                cmd <= {cmd[6:0], si};
            end
        end
    end
    property p_hdr_in;
        @(posedge sclk) disable iff (srst_i || cs_n)
        cnt != 6'h00 && cnt < 6'h08 |-> so_dev_oe_n;
    endproperty
    a_hdr_in: assert property (p_hdr_in) else $error("so driven early");
    property p_prog_in;
        @(posedge sclk) disable iff (srst_i || cs_n)
        cnt >= 6'h08 && (cmd == `MPP_CMD_DUAL || cmd == `MPP_CMD_QUAD)
            |-> so_dev_oe_n;
    endproperty
    a_prog_in: assert property (p_prog_in) else $error("so not input");
    property p_rdsr;
        @(posedge sclk) disable iff (srst_i || cs_n)
        cmd == `MPP_CMD_RDSR && cnt >= 6'h08 && cnt <= 6'h0d
            |-> !so_dev_oe_n && !so_dev;
    endproperty
    a_rdsr: assert property (p_rdsr) else $error("bad status bits");
    property p_asi;
        @(posedge sclk) disable iff (srst_i || cs_n)
        cmd == `MPP_CMD_ASI && cnt >= 6'h09 |-> !so_dev_oe_n;
    endproperty
    a_asi: assert property (p_asi) else $error("busy not driven");
    property p_dual_lane;
        @(posedge sclk) disable iff (srst_i || cs_n)
        cmd == `MPP_CMD_DUAL && cnt >= 6'h20 |-> !so_host_oe_n;
    endproperty
    a_dual_lane: assert property (p_dual_lane) else $error("dual lane");
    property p_quad_lane;
        @(posedge sclk) disable iff (srst_i || cs_n)
        cmd == `MPP_CMD_QUAD && cnt >= 6'h20 |-> !so_host_oe_n;
    endproperty
    a_quad_lane: assert property (p_quad_lane) else $error("quad lane");
    property p_idle_clk;
        @(posedge clk_sys_i) disable iff (srst_i)
        cs_n |-> !sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("sclk high");
    property p_half;
        @(posedge clk_sys_i) disable iff (srst_i)
        $rose(sclk) |=> sclk [*4] ##1 !sclk;
    endproperty
    a_half: assert property (p_half) else $error("sclk period");
endmodule

//--- tb_top.sv
// Testbench joining the host end and the flash end over the link.
`timescale 1ns/1ps
module tb_top;
    import mpp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_i = 1'b0, qe = 1'b0, fail = 1'b0, clr = 1'b0;
    mpp_op_t op_i = OP_WREN;
    logic [23:0] addr_i = 24'h000000, ad, maddr;
    logic [9:0] len_i = 10'h000;
    logic [2:0] extra_i = 3'h0;
    logic [7:0] byte_i = 8'h00, prot = 8'h00, status_o, mdata;
    logic ready_o, take, done_o, busy, write_enable_latch, ee, pe, we;
    logic [7:0] dat [512];
    logic [31:0] q [$];
    logic [31:0] seed = 32'h5058c57d;
    int fail_count = 0, checks_done = 0, idx = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    mpp_link_if lk();
    mpp_host_end u_mpp_host_end(.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .ce_i(1'b1), .req_i(req_i), .op_i(op_i), .addr_i(addr_i),
        .len_i(len_i), .extra_i(extra_i), .byte_i(byte_i),
        .ready_o(ready_o), .byte_take_o(take), .done_o(done_o),
        .status_o(status_o), .link(lk.host));
    mpp_flash_end u_mpp_flash_end(.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .ce_i(1'b1), .quad_lane_enable_i(qe), .protect_i(prot),
        .mem_fail_i(fail), .mem_we_o(we), .mem_addr_o(maddr),
        .mem_data_o(mdata), .err_clr_i(clr), .busy_flag_o(busy),
        .write_enable_latch_o(write_enable_latch), .erase_error_flag_o(ee),
        .program_error_flag_o(pe), .link(lk.dev));
    mpp_link_sva u_chk(.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .sclk(lk.sclk), .cs_n(lk.cs_n), .si(lk.si), .so_dev(lk.so_dev),
        .so_dev_oe_n(lk.so_dev_oe_n), .so_host_oe_n(lk.so_host_oe_n));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic fl(input logic [3:0] e);
        cmp(32'({busy, write_enable_latch, ee, pe}), 32'(e));
    endtask
    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic frame(input mpp_op_t o, input logic [23:0] a,
                         input logic [9:0] n, input logic [2:0] x);
        int i;
        while (ready_o !== 1'b1) begin
            @(posedge clk_sys_i);
            #1;
        end
        op_i = o;
        addr_i = a;
        len_i = n;
        extra_i = x;
        idx = 0;
        byte_i = dat[0];
        req_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        req_i = 1'b0;
        for (i = 0; i < 30000 && done_o !== 1'b1; i++) @(posedge clk_sys_i);
        #1;
        if (i == 30000) fail_count++;
    endtask
    // Notes the expected array writes, then sends the program frame.
    task automatic prog(input mpp_op_t o, input logic [23:0] a,
        input logic [9:0] n, input logic [2:0] x, input logic ok, en);
        int k;
        if (en) frame(OP_WREN, 24'h000000, 10'h000, 3'h0);
        for (k = 0; k < 512; k++) dat[k] = rnd();
        for (k = 0; ok && k < 256 && k < n; k++) q.push_back({a[23:8],
            a[7:0] + k[7:0], dat[(n > 256 && k < n - 256) ? k + 256 : k]});
        frame(o, a, n, x);
    endtask
    task automatic idle();
        int k;
        repeat (5) @(posedge clk_sys_i);
        for (k = 0; k < 8000 && busy !== 1'b0; k++) @(posedge clk_sys_i);
        #1;
        if (k == 8000) fail_count++;
    endtask
    always @(posedge clk_sys_i) begin
        if (take === 1'b1) begin
            #1;
            idx = idx + 1;
            byte_i = dat[idx];
        end
    end
    always @(posedge clk_sys_i) begin
        if (we === 1'b1) begin
            cmp({maddr, mdata}, q.size() != 0 ? q.pop_front() : 32'hx);
        end
    end
    initial begin
        #400000;
        fail_count++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        srst_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        ad = {rnd(), rnd(), rnd()};
        prog(OP_DUAL, 24'h0000fe, 10'h003, 3'h0, 1'b1, 1'b1);
        idle();
        fl(4'h0);
        prog(OP_DUAL, ad, 10'h001, 3'h0, 1'b0, 1'b0);
        idle();
        fl(4'h0);
        prog(OP_QUAD, ad, 10'h014, 3'h0, 1'b0, 1'b1);
        idle();
        fl(4'h4);
        qe = 1'b1;
        prog(OP_QUAD, ad, 10'h014, 3'h0, 1'b1, 1'b1);
        frame(OP_RDSR, 24'h000000, 10'h000, 3'h0);
        cmp(32'(status_o), 32'h00000003);
        frame(OP_ASI, 24'h000000, 10'h000, 3'h0);
        cmp(32'(status_o[0]), 32'h00000000);
        fl(4'h0);
        prog(OP_DUAL, ad, 10'h002, 3'h3, 1'b0, 1'b1);
        idle();
        fl(4'h0);
        prog(OP_DUAL, ad, 10'h000, 3'h0, 1'b0, 1'b1);
        idle();
        fl(4'h0);
        prog(OP_QUAD, ad, 10'h002, 3'h1, 1'b0, 1'b1);
        idle();
        fl(4'h0);
        prot = 8'h01 << ad[18:16];
        prog(OP_DUAL, ad, 10'h004, 3'h0, 1'b0, 1'b1);
        idle();
        fl(4'h0);
        prot = 8'h00;
        fail = 1'b1;
        prog(OP_DUAL, ad, 10'h001, 3'h0, 1'b1, 1'b1);
        idle();
        fl(4'h3);
        fail = 1'b0;
        clr = 1'b1;
        @(posedge clk_sys_i);
        #1;
        clr = 1'b0;
        fl(4'h0);
        prog(OP_QUAD, ad, 10'h102, 3'h0, 1'b1, 1'b1);
        idle();
        fl(4'h0);
        cmp(32'(q.size()), 32'h00000000);
        results();
    end
endmodule
